// ===== hdl/ulsr_defs.svh
/*
 * Constants of the UART interrupt-enable and line-status register block.
 * Assumes inclusion by bare name from the hdl folder.
 */
`ifndef ULSR_DEFS_SVH
`define ULSR_DEFS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define ULSR_LVL_W       6

// ****************************************************************
// Register addresses on the three-bit bus
// ****************************************************************
`define ULSR_A_HOLD      3'h0
`define ULSR_A_MASK      3'h1
`define ULSR_A_ISR       3'h2
`define ULSR_A_LCR       3'h3
`define ULSR_A_MCR       3'h4
`define ULSR_A_LSR       3'h5
`define ULSR_A_MSR       3'h6
`define ULSR_A_SPR       3'h7
`define ULSR_A_RES1      3'h4
`define ULSR_A_RES2      3'h5
`define ULSR_A_PAU1      3'h6
`define ULSR_A_PAU2      3'h7

// ****************************************************************
// Field positions and special values
// ****************************************************************
`define ULSR_LCR_ENH     8'hbf
`define ULSR_LCR_DIV     7
`define ULSR_EFR_ENH     4
`define ULSR_XFR_LSRM    3
`define ULSR_FCR_EN      0
`define ULSR_IER_RX      0
`define ULSR_IER_TX      1
`define ULSR_IER_LS      2
`define ULSR_IER_MS      3
`define ULSR_LOW_MASK    8'h0f
`define ULSR_RST         8'h00

// ****************************************************************
// Interrupt source codes in status bits 3..0
// ****************************************************************
`define ULSR_SRC_LS      4'h6
`define ULSR_SRC_RX      4'h4
`define ULSR_SRC_TX      4'h2
`define ULSR_SRC_MS      4'h0
`define ULSR_SRC_NONE    4'h1

`endif

// ===== hdl/ulsr_pkg.sv
/*
 * Types of the UART interrupt-enable and line-status register block.
 * Assumes ulsr_defs.svh is on the include path.
 */
`include "ulsr_defs.svh"

package ulsr_pkg;

  // ****************************************************************
  // Receive side status, driven by the receive FIFO logic.
  // ****************************************************************
  typedef struct packed {
    logic [`ULSR_LVL_W-1:0] level;
    logic [2:0]             head_err;
    logic                   push;
    logic [2:0]             push_err;
    logic                   overrun;
    logic                   err_any;
  } ulsr_rx_s;

  // ****************************************************************
  // Transmit side status, driven by the transmit FIFO logic.
  // ****************************************************************
  typedef struct packed {
    logic [`ULSR_LVL_W-1:0] level;
    logic                   tsr_empty;
  } ulsr_tx_s;

  // ****************************************************************
  // Configuration handed to the rest of the UART.
  // ****************************************************************
  typedef struct packed {
    logic [15:0] divisor;
    logic [7:0]  line_format;
    logic [7:0]  enh;
    logic [7:0]  extra;
    logic [7:0]  mask;
    logic [7:0]  modem_ctl;
    logic        fifo_en;
    logic [1:0]  rx_trig_sel;
    logic [1:0]  tx_trig_sel;
    logic [7:0]  res1;
    logic [7:0]  res2;
    logic [7:0]  pau1;
    logic [7:0]  pau2;
  } ulsr_cfg_s;

endpackage

// ===== hdl/ulsr_regs.sv
/*
 * Register file, line status and interrupt enables of a UART with
 * transmit and receive FIFOs, reached over an 8-bit parallel bus.
 * Assumes bus strobes and FIFO status come from logic on core_clk_i,
 * one-cycle strobes, and that the FIFOs themselves live elsewhere.
 */
`timescale 1ns/1ps
`include "ulsr_defs.svh"

module ulsr_regs #(
  parameter int              FIFO_DEPTH = 32,
  parameter logic [7:0]      DEV_ID     = 8'h5a, // Arbitrary value.
  parameter logic [7:0]      DEV_REV    = 8'h01, // Arbitrary value.
  parameter logic [`ULSR_LVL_W-1:0] RX_T0 = 6'h01,
  parameter logic [`ULSR_LVL_W-1:0] RX_T1 = 6'h08,
  parameter logic [`ULSR_LVL_W-1:0] RX_T2 = 6'h10,
  parameter logic [`ULSR_LVL_W-1:0] RX_T3 = 6'h1c,
  parameter logic [`ULSR_LVL_W-1:0] TX_T0 = 6'h01,
  parameter logic [`ULSR_LVL_W-1:0] TX_T1 = 6'h08,
  parameter logic [`ULSR_LVL_W-1:0] TX_T2 = 6'h10,
  parameter logic [`ULSR_LVL_W-1:0] TX_T3 = 6'h18
) (
  input  wire logic              core_clk_i,
  input  wire logic              srst_i,
  input  wire logic              cs_i,
  input  wire logic              rd_i,
  input  wire logic              wr_i,
  input  wire logic [2:0]        addr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic [7:0]        rx_data_i,
  input  wire logic [7:0]        msr_i,
  input  wire logic              msr_int_i,
  input  wire ulsr_pkg::ulsr_rx_s rx_i,
  input  wire ulsr_pkg::ulsr_tx_s tx_i,
  output logic [7:0]             rdata_o,
  output logic                   rhr_rd_o,
  output logic                   thr_wr_o,
  output logic [7:0]             thr_data_o,
  output logic                   irq_o,
  output ulsr_pkg::ulsr_cfg_s    cfg_o
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  // The level fields must hold a full FIFO count.
  if (FIFO_DEPTH < 1 || FIFO_DEPTH >= (1 << `ULSR_LVL_W)) begin : g_chk
    $error("FIFO_DEPTH does not fit the level width");
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Picks one of four trigger levels.
  function automatic logic [`ULSR_LVL_W-1:0] pick(
    input logic [1:0]             sel,
    input logic [`ULSR_LVL_W-1:0] t0,
    input logic [`ULSR_LVL_W-1:0] t1,
    input logic [`ULSR_LVL_W-1:0] t2,
    input logic [`ULSR_LVL_W-1:0] t3);
    logic [`ULSR_LVL_W-1:0] r;
    r = t0;
    unique case (sel)
      2'h0: r = t0;
      2'h1: r = t1;
      2'h2: r = t2;
      2'h3: r = t3;
    endcase
    return r;
  endfunction

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic       div_mode;
  logic       enh_mode;
  logic       enh_on;
  logic       rd_hit;
  logic       wr_hit;
  logic [7:0] line_condition;
  logic [7:0] interrupt_source_status;
  logic [3:0] src;
  logic [`ULSR_LVL_W-1:0] rx_trig;
  logic [`ULSR_LVL_W-1:0] tx_trig;
  logic       rx_cond;
  logic       tx_cond;
  logic       tx_cond_q;
  logic       tx_pend;
  logic       ls_pend;
  logic       ovr_flag;
  logic [2:0] head_q;
  logic [7:0] spr;

  // Bank selection follows the line format register.
  assign div_mode = cfg_o.line_format[`ULSR_LCR_DIV];
  assign enh_mode = cfg_o.line_format == `ULSR_LCR_ENH;
  assign enh_on   = cfg_o.enh[`ULSR_EFR_ENH];
  assign rd_hit   = cs_i & rd_i;
  assign wr_hit   = cs_i & wr_i;
  assign rx_trig  = pick(cfg_o.rx_trig_sel, RX_T0, RX_T1, RX_T2, RX_T3);
  assign tx_trig  = pick(cfg_o.tx_trig_sel, TX_T0, TX_T1, TX_T2, TX_T3);

  // ****************************************************************
  // Line status and interrupt sources
  // ****************************************************************
  // Receiver and transmitter report separately for polled use.
  assign line_condition[0]   = rx_i.level != '0;
  assign line_condition[1]   = ovr_flag;
  assign line_condition[4:2] = rx_i.head_err;
  assign line_condition[5]   = cfg_o.fifo_en ? tx_i.level == '0
                                  : tx_i.level == '0;
  assign line_condition[6]   = tx_i.level == '0 && tx_i.tsr_empty;
  assign line_condition[7]   = cfg_o.fifo_en & rx_i.err_any;

  // Receive source is a level: trigger in FIFO mode, else data held.
  assign rx_cond = cfg_o.fifo_en ? rx_i.level >= rx_trig
                                 : line_condition[0];
  // Transmit condition: FIFO below trigger, else holding empty.
  assign tx_cond = cfg_o.fifo_en ? rx_lt(tx_i.level, tx_trig)
                                 : line_condition[5];

  // Compares a FIFO level against a trigger.
  function automatic logic rx_lt(
    input logic [`ULSR_LVL_W-1:0] a,
    input logic [`ULSR_LVL_W-1:0] b);
    return a < b;
  endfunction

  // Highest enabled pending source is reported.
  always_comb begin
    src = `ULSR_SRC_NONE;
    if (cfg_o.mask[`ULSR_IER_LS] && ls_pend) begin
      src = `ULSR_SRC_LS;
    end else if (cfg_o.mask[`ULSR_IER_RX] && rx_cond) begin
      src = `ULSR_SRC_RX;
    end else if (cfg_o.mask[`ULSR_IER_TX] && tx_pend) begin
      src = `ULSR_SRC_TX;
    end else if (cfg_o.mask[`ULSR_IER_MS] && msr_int_i) begin
      src = `ULSR_SRC_MS;
    end
  end

  assign interrupt_source_status = {{2{cfg_o.fifo_en}}, 2'h0, src};

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // Divisor latches, written only through their own bank.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cfg_o.divisor <= {`ULSR_RST, `ULSR_RST};
    end else if (wr_hit && div_mode) begin
      // Identity codes share these addresses but are read only.
      if (addr_i == `ULSR_A_HOLD) begin
        cfg_o.divisor[7:0] <= wdata_i;
      end else if (addr_i == `ULSR_A_MASK && !enh_mode) begin
        cfg_o.divisor[15:8] <= wdata_i;
      end
    end
  end

  // Line format register, reachable in every bank.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cfg_o.line_format <= `ULSR_RST;
    end else if (wr_hit && addr_i == `ULSR_A_LCR) begin
      cfg_o.line_format <= wdata_i;
    end
  end

  // Enhanced and flow character registers, bank 0xbf only.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cfg_o.enh  <= `ULSR_RST;
      cfg_o.res1 <= `ULSR_RST;
      cfg_o.res2 <= `ULSR_RST;
      cfg_o.pau1 <= `ULSR_RST;
      cfg_o.pau2 <= `ULSR_RST;
    end else if (wr_hit && enh_mode) begin
      unique case (addr_i)
        `ULSR_A_ISR:  cfg_o.enh  <= wdata_i;
        `ULSR_A_RES1: cfg_o.res1 <= wdata_i;
        `ULSR_A_RES2: cfg_o.res2 <= wdata_i;
        `ULSR_A_PAU1: cfg_o.pau1 <= wdata_i;
        `ULSR_A_PAU2: cfg_o.pau2 <= wdata_i;
        default: ;
      endcase
    end
  end

  // Normal bank: mask, FIFO setup, modem, extra and scratch.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cfg_o.mask        <= `ULSR_RST;
      cfg_o.fifo_en     <= 1'b0;
      cfg_o.rx_trig_sel <= 2'h0;
      cfg_o.tx_trig_sel <= 2'h0;
      cfg_o.modem_ctl   <= `ULSR_RST;
      cfg_o.extra       <= `ULSR_RST;
      spr               <= `ULSR_RST;
    end else if (wr_hit && !div_mode) begin
      unique case (addr_i)
        `ULSR_A_MASK: begin
          // Upper enables need the enhanced bit.
          cfg_o.mask <= enh_on ? wdata_i
                               : wdata_i & `ULSR_LOW_MASK;
        end
        `ULSR_A_ISR: begin
          cfg_o.fifo_en <= wdata_i[`ULSR_FCR_EN];
          // Other fields take effect only with the enable bit set.
          if (wdata_i[`ULSR_FCR_EN]) begin
            cfg_o.rx_trig_sel <= wdata_i[7:6];
            if (enh_on) begin
              cfg_o.tx_trig_sel <= wdata_i[5:4];
            end
          end
        end
        `ULSR_A_MCR: begin
          cfg_o.modem_ctl <= enh_on ? wdata_i
                                    : {3'h0, wdata_i[4:0]};
        end
        `ULSR_A_LSR: begin
          if (enh_on) begin
            cfg_o.extra <= wdata_i;
          end
        end
        `ULSR_A_SPR: spr <= wdata_i;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Holding register strobes
  // ****************************************************************
  // One-cycle strobes toward the FIFOs for data reads and writes.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rhr_rd_o   <= 1'b0;
      thr_wr_o   <= 1'b0;
      thr_data_o <= `ULSR_RST;
    end else begin
      rhr_rd_o <= rd_hit && !div_mode && addr_i == `ULSR_A_HOLD;
      thr_wr_o <= wr_hit && !div_mode && addr_i == `ULSR_A_HOLD;
      if (wr_hit && !div_mode && addr_i == `ULSR_A_HOLD) begin
        thr_data_o <= wdata_i;
      end
    end
  end

  // ****************************************************************
  // Sticky line status flags
  // ****************************************************************
  // Overrun flag; a new overrun in the clearing read wins.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ovr_flag <= 1'b0;
    end else if (rx_i.overrun) begin
      ovr_flag <= 1'b1;
    end else if (rd_hit && !div_mode && addr_i == `ULSR_A_LSR) begin
      ovr_flag <= 1'b0;
    end
  end

  // Line status interrupt: set by overrun or error, cleared by read.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      head_q  <= 3'h0;
      ls_pend <= 1'b0;
    end else begin
      head_q <= rx_i.head_err;
      if (rx_i.overrun
          || (cfg_o.extra[`ULSR_XFR_LSRM]
              && rx_i.push && rx_i.push_err != 3'h0)
          || (!cfg_o.extra[`ULSR_XFR_LSRM]
              && rx_i.head_err != 3'h0
              && rx_i.head_err != head_q)) begin
        ls_pend <= 1'b1;
      end else if (rd_hit && !div_mode && addr_i == `ULSR_A_LSR) begin
        ls_pend <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Transmit ready latch
  // ****************************************************************
  // Set on the condition's rise or on enabling while it holds.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tx_cond_q <= 1'b0;
      tx_pend   <= 1'b0;
    end else begin
      tx_cond_q <= tx_cond;
      if ((tx_cond && !tx_cond_q)
          || (wr_hit && !div_mode && addr_i == `ULSR_A_MASK
              && wdata_i[`ULSR_IER_TX] && tx_cond)) begin
        tx_pend <= 1'b1;
      end else if ((wr_hit && !div_mode && addr_i == `ULSR_A_HOLD)
                   || (rd_hit && !div_mode && addr_i == `ULSR_A_ISR
                       && src == `ULSR_SRC_TX)) begin
        tx_pend <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Interrupt output
  // ****************************************************************
  // Active when any enabled source is pending.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= src != `ULSR_SRC_NONE;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Registered read mux; unreachable locations read as zero.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rdata_o <= `ULSR_RST;
    end else if (rd_hit) begin
      rdata_o <= `ULSR_RST;
      if (addr_i == `ULSR_A_LCR) begin
        rdata_o <= cfg_o.line_format;
      end else if (enh_mode) begin
        unique case (addr_i)
          `ULSR_A_HOLD: rdata_o <= cfg_o.divisor[7:0];
          `ULSR_A_ISR:  rdata_o <= cfg_o.enh;
          `ULSR_A_RES1: rdata_o <= cfg_o.res1;
          `ULSR_A_RES2: rdata_o <= cfg_o.res2;
          `ULSR_A_PAU1: rdata_o <= cfg_o.pau1;
          `ULSR_A_PAU2: rdata_o <= cfg_o.pau2;
          default: ;
        endcase
      end else if (div_mode) begin
        // Identity shows while both latches are zero.
        if (addr_i == `ULSR_A_HOLD) begin
          rdata_o <= cfg_o.divisor == '0 ? DEV_REV
                                         : cfg_o.divisor[7:0];
        end else if (addr_i == `ULSR_A_MASK) begin
          rdata_o <= cfg_o.divisor == '0 ? DEV_ID
                                         : cfg_o.divisor[15:8];
        end
      end else begin
        unique case (addr_i)
          `ULSR_A_HOLD: rdata_o <= rx_data_i;
          `ULSR_A_MASK: rdata_o <= cfg_o.mask;
          `ULSR_A_ISR:  rdata_o <= interrupt_source_status;
          `ULSR_A_MCR:  rdata_o <= cfg_o.modem_ctl;
          `ULSR_A_LSR:  rdata_o <= line_condition;
          `ULSR_A_MSR:  rdata_o <= enh_on ? msr_i
                                          : {4'h0, msr_i[3:0]};
          `ULSR_A_SPR:  rdata_o <= spr;
          default: ;
        endcase
      end
    end
  end

endmodule

// ===== testbench/ulsr_regs_asserts.sv
/*
 * Checker for the UART line-status and interrupt-enable register block.
 * Assumes one clock domain and a synchronous active-high reset.
 */
`timescale 1ns/1ps

// ****************************************************************
// Checker
// ****************************************************************
module ulsr_regs_asserts (
  input wire logic                core_clk_i,
  input wire logic                srst_i,
  input wire logic                cs_i,
  input wire logic                rd_i,
  input wire logic                wr_i,
  input wire logic [2:0]          addr_i,
  input wire logic [7:0]          wdata_i,
  input wire ulsr_pkg::ulsr_rx_s  rx_i,
  input wire ulsr_pkg::ulsr_tx_s  tx_i,
  input wire logic [7:0]          rdata_o,
  input wire logic                irq_o,
  input wire ulsr_pkg::ulsr_cfg_s cfg_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  // A read of line status in the normal bank.
  logic lsr_rd;
  assign lsr_rd = cs_i && rd_i && addr_i == 3'h5 && !cfg_o.line_format[7];

  a_lsr_ready: assert property (lsr_rd |=>
    rdata_o[0] == ($past(rx_i.level) != 6'h00)) else $error("ready bit");
  a_lsr_errs: assert property (lsr_rd |=>
    rdata_o[4:2] == $past(rx_i.head_err)) else $error("error bits");
  a_lsr_tx_empty: assert property (lsr_rd |=>
    rdata_o[6:5] == {$past(tx_i.tsr_empty) && $past(tx_i.level) == 6'h00,
    $past(tx_i.level) == 6'h00}) else $error("transmit empty bits");
  a_lsr_fifo_err: assert property (lsr_rd |=>
    rdata_o[7] == ($past(cfg_o.fifo_en) && $past(rx_i.err_any)))
    else $error("fifo error bit");
  a_mask_reset: assert property ($fell(srst_i) |->
    cfg_o.mask[2:0] == 3'h0) else $error("mask not cleared");
  a_ovr_irq: assert property (rx_i.overrun && cfg_o.mask[2] |->
    ##[1:3] irq_o) else $error("overrun interrupt late");
  a_tx_arm_irq: assert property (cs_i && wr_i && addr_i == 3'h1
    && wdata_i[1] && !cfg_o.line_format[7] && !cfg_o.fifo_en
    && tx_i.level == 6'h00 |-> ##[1:3] irq_o) else $error("tx arm");
  a_div_guard: assert property (cs_i && wr_i && addr_i == 3'h1
    && cfg_o.line_format == 8'hbf |=> $stable(cfg_o.divisor))
    else $error("divisor changed");
  a_quiet_mask: assert property ((cfg_o.mask[3:0] == 4'h0) [*3]
    |-> !irq_o) else $error("interrupt while masked");

  c_overrun: cover property (lsr_rd ##1 rdata_o[1]);
  c_fifo_irq: cover property (irq_o && cfg_o.fifo_en);
  c_irq_rise: cover property ($rose(irq_o));
endmodule

bind ulsr_regs ulsr_regs_asserts u_chk (.core_clk_i(core_clk_i),
  .srst_i(srst_i), .cs_i(cs_i), .rd_i(rd_i), .wr_i(wr_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .rx_i(rx_i), .tx_i(tx_i),
  .rdata_o(rdata_o), .irq_o(irq_o), .cfg_o(cfg_o));

// ===== testbench/ulsr_fifo_model.sv
/*
 * Behavioural model of the receive and transmit FIFO status logic.
 * Assumes pulses from the bench and the block on the same clock.
 */
`timescale 1ns/1ps

// ****************************************************************
// FIFO status model
// ****************************************************************
module ulsr_fifo_model (
  input  wire logic          clk_i,
  input  wire logic          srst_i,
  input  wire logic          push_i,
  input  wire logic [2:0]    err_i,
  input  wire logic          ovr_i,
  input  wire logic          pop_i,
  input  wire logic          tx_push_i,
  input  wire logic          tx_pop_i,
  input  wire logic          tsr_empty_i,
  output ulsr_pkg::ulsr_rx_s rx_o,
  output ulsr_pkg::ulsr_tx_s tx_o
);
  logic [31:0][2:0] errs;
  logic [5:0]       lvl;
  logic [5:0]       tlvl;

  // Counts and error flags update locally, outputs move by NBA.
  always @(posedge clk_i) begin
    if (srst_i) begin
      errs = '0;
      lvl = 6'h00;
      tlvl = 6'h00;
    end else begin
      if (pop_i && lvl != 6'h00) begin
        errs = errs >> 3;
        lvl = lvl - 6'h01;
      end
      if (push_i && lvl < 6'h20) begin
        errs[lvl[4:0]] = err_i;
        lvl = lvl + 6'h01;
      end
      if (tx_pop_i && tlvl != 6'h00) begin
        tlvl = tlvl - 6'h01;
      end
      if (tx_push_i) begin
        tlvl = tlvl + 6'h01;
      end
    end
    rx_o <= {lvl, errs[0], push_i & ~srst_i, err_i, ovr_i & ~srst_i, |errs};
    tx_o <= {tlvl, tsr_empty_i};
  end
endmodule

// ===== testbench/tb_uart_irq_enable_line_status.sv
/*
 * Self-checking bench for the UART line-status register block.
 * Assumes the FIFO status model and the bound checker.
 */
`timescale 1ns/1ps

// ****************************************************************
// Bench
// ****************************************************************
module tb_uart_irq_enable_line_status;
  logic               core_clk_i = 1'b0;
  logic               srst_i = 1'b1;
  logic               cs_i = 1'b0;
  logic               rd_i = 1'b0;
  logic               wr_i = 1'b0;
  logic [2:0]         addr_i = 3'h0;
  logic [7:0]         wdata_i = 8'h00;
  logic [7:0]         rx_data_i = 8'ha5;
  logic               push_i = 1'b0;
  logic [2:0]         err_i = 3'h0;
  logic               ovr_i = 1'b0;
  logic               txpop_i = 1'b0;
  logic               tsr_i = 1'b1;
  logic [7:0]         msr_i = 8'h00;
  logic               msr_int_i = 1'b0;
  logic [7:0]         rdata_o;
  logic               rhr_rd_o;
  logic               thr_wr_o;
  logic [7:0]         thr_data_o;
  logic               irq_o;
  ulsr_pkg::ulsr_cfg_s cfg_o;
  ulsr_pkg::ulsr_rx_s  rx_s;
  ulsr_pkg::ulsr_tx_s  tx_s;
  int                 miscompares = 0;
  int                 num_checks = 0;

  // Clock of 5 ns period.
  always #2.5 core_clk_i = ~core_clk_i;

  ulsr_regs u_dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .cs_i(cs_i),
    .rd_i(rd_i), .wr_i(wr_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .rx_data_i(rx_data_i), .msr_i(msr_i), .msr_int_i(msr_int_i),
    .rx_i(rx_s),
    .tx_i(tx_s), .rdata_o(rdata_o), .rhr_rd_o(rhr_rd_o),
    .thr_wr_o(thr_wr_o), .thr_data_o(thr_data_o), .irq_o(irq_o),
    .cfg_o(cfg_o));

  ulsr_fifo_model u_fifo (.clk_i(core_clk_i), .srst_i(srst_i),
    .push_i(push_i), .err_i(err_i), .ovr_i(ovr_i), .pop_i(rhr_rd_o),
    .tx_push_i(thr_wr_o), .tx_pop_i(txpop_i), .tsr_empty_i(tsr_i),
    .rx_o(rx_s), .tx_o(tx_s));

  task automatic end_of_test;
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk_i) {cs_i, wr_i, addr_i, wdata_i} <= {2'b11, a, d};
    @(posedge core_clk_i) {cs_i, wr_i} <= 2'b00;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge core_clk_i) {cs_i, rd_i, addr_i} <= {2'b11, a};
    @(posedge core_clk_i) {cs_i, rd_i} <= 2'b00;
    #1 chk("rdata", e, rdata_o);
  endtask

  // One-cycle pulse on push, overrun or transmit drain.
  task automatic ev(input logic [2:0] p, input logic [2:0] e);
    @(posedge core_clk_i) {push_i, ovr_i, txpop_i, err_i} <= {p, e};
    @(posedge core_clk_i) {push_i, ovr_i, txpop_i} <= 3'h0;
  endtask

  task automatic ck_irq(input logic e);
    repeat (4) @(posedge core_clk_i);
    #1 chk("irq", {7'h00, e}, {7'h00, irq_o});
  endtask

  // Guard against a hung run.
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    repeat (3) @(posedge core_clk_i);
    srst_i <= 1'b0;
    rd(3'h1, 8'h00);
    rd(3'h5, 8'h60);
    wr(3'h3, 8'h80);
    // Both latches are zero, so the identity view shows.
    rd(3'h0, 8'h01);
    rd(3'h1, 8'h5a);
    wr(3'h0, 8'h12);
    wr(3'h1, 8'h34);
    rd(3'h0, 8'h12);
    rd(3'h1, 8'h34);
    wr(3'h3, 8'hbf);
    wr(3'h1, 8'h77);
    wr(3'h2, 8'h10);
    for (int k = 4; k < 8; k++) wr(3'(k), 8'(k) * 8'h11);
    for (int k = 4; k < 8; k++) rd(3'(k), 8'(k) * 8'h11);
    rd(3'h2, 8'h10);
    rd(3'h1, 8'h00);
    chk("divisor high", 8'h34, cfg_o.divisor[15:8]);
    wr(3'h3, 8'h03);
    wr(3'h1, 8'h01);
    ev(3'b100, 3'h0);
    ck_irq(1'b1);
    rd(3'h5, 8'h61);
    rd(3'h2, 8'h04);
    rd(3'h0, 8'ha5);
    ck_irq(1'b0);
    rd(3'h5, 8'h60);
    wr(3'h1, 8'h02);
    ck_irq(1'b1);
    rd(3'h2, 8'h02);
    ck_irq(1'b0);
    // Pending is clear and no edge follows, so only arming can raise it.
    wr(3'h1, 8'h02);
    ck_irq(1'b1);
    rd(3'h2, 8'h02);
    wr(3'h1, 8'h04);
    ev(3'b010, 3'h0);
    ck_irq(1'b1);
    rd(3'h5, 8'h62);
    ck_irq(1'b0);
    rd(3'h5, 8'h60);
    wr(3'h2, 8'h41);
    ev(3'b100, 3'h1);
    ck_irq(1'b1);
    rd(3'h5, 8'he5);
    rd(3'h0, 8'ha5);
    rd(3'h5, 8'h60);
    wr(3'h1, 8'h01);
    repeat (7) ev(3'b100, 3'h0);
    ck_irq(1'b0);
    rd(3'h2, 8'hc1);
    ev(3'b100, 3'h0);
    ck_irq(1'b1);
    rd(3'h2, 8'hc4);
    rd(3'h0, 8'ha5);
    ck_irq(1'b0);
    rd(3'h2, 8'hc1);
    wr(3'h1, 8'h00);
    ck_irq(1'b0);
    rd(3'h5, 8'h61);
    wr(3'h0, 8'h5a);
    #1 chk("tx byte", 8'h5a, thr_data_o);
    rd(3'h5, 8'h01);
    @(posedge core_clk_i) tsr_i <= 1'b0;
    ev(3'b001, 3'h0);
    rd(3'h5, 8'h21);
    @(posedge core_clk_i) tsr_i <= 1'b1;
    rd(3'h5, 8'h61);
    // Error interrupt on reception: the bad byte is at the tail.
    wr(3'h5, 8'h08);
    wr(3'h1, 8'h04);
    ev(3'b100, 3'h2);
    ck_irq(1'b1);
    rd(3'h5, 8'he1);
    ck_irq(1'b0);
    // Modem source and the full modem status byte.
    wr(3'h1, 8'h08);
    @(posedge core_clk_i) {msr_i, msr_int_i} <= {8'ha7, 1'b1};
    ck_irq(1'b1);
    rd(3'h2, 8'hc0);
    rd(3'h6, 8'ha7);
    @(posedge core_clk_i) msr_int_i <= 1'b0;
    ck_irq(1'b0);
    end_of_test();
  end
endmodule
